// ### hw/load_filter.v
`timescale 1ns/10ps
`include "stall_detect_consts.vh"

module load_filter #(
    parameter W = `LOAD_WIDTH
) (
    input  wire         i_mclk,
    input  wire         i_resetn,
    input  wire         i_clear,
    input  wire         i_sample_valid,
    input  wire [W-1:0] i_sample,
    output reg  [W-1:0] o_mean,
    output reg          o_mean_valid
);

// ----------------------------------------------------------------------
// three-entry history; the current sample is the fourth term of the mean
// ----------------------------------------------------------------------
    reg  [W-1:0] hist [0:2];
    reg  [1:0]   fill;
    wire [W+1:0] sum;

    assign sum = {2'b00, hist[0]} + {2'b00, hist[1]} + {2'b00, hist[2]}
               + {2'b00, i_sample};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_hist
            // head and tail split so no entry ever indexes below zero
            if (g == 0) begin : g_head
                always @(posedge i_mclk) begin
                    if (!i_resetn || i_clear) begin
                        hist[g] <= {W{1'b0}};
                    end else if (i_sample_valid) begin
                        hist[g] <= i_sample;
                    end
                end
            end else begin : g_tail
                always @(posedge i_mclk) begin
                    if (!i_resetn || i_clear) begin
                        hist[g] <= {W{1'b0}};
                    end else if (i_sample_valid) begin
                        hist[g] <= hist[g-1];
                    end
                end
            end
        end
    endgenerate

    // mean of last four, emitted every fourth sample
    always @(posedge i_mclk) begin
        if (!i_resetn || i_clear) begin
            fill         <= 2'b00;
            o_mean       <= `LOAD_RESULT_RESET;
            o_mean_valid <= 1'b0;
        end else begin
            o_mean_valid <= 1'b0;
            if (i_sample_valid) begin
                fill <= fill + 2'b01;
                if (fill == 2'b11) begin
                    o_mean       <= sum[W+1:2];
                    o_mean_valid <= 1'b1;
                end
            end
        end
    end

endmodule

// ### hw/stall_detect.v
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "stall_detect_consts.vh"

module stall_detect #(
    parameter LW = `LOAD_WIDTH,
    parameter TW = `INTERVAL_WIDTH
) (
    input  wire          i_mclk,
    input  wire          i_resetn,
    // step and measurement front end
    input  wire          i_full_step,
    input  wire [LW-1:0] i_raw_load,
    // avalon-mm slave
    input  wire [4:0]    i_avs_address,
    input  wire          i_avs_read,
    input  wire          i_avs_write,
    input  wire [31:0]   i_avs_writedata,
    output reg  [31:0]   o_avs_readdata,
    output wire          o_avs_waitrequest,
    // diagnostics
    output reg           o_diagnostic_output_a,
    output reg           o_diagnostic_output_b,
    output wire          o_irq
);

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
    reg  [10:0]          control;
    reg  [TW-1:0]        lower_velocity_threshold;
    reg  [TW-1:0]        upper_velocity_threshold;
    reg  [TW-1:0]        step_interval_measure;
    reg  [TW-1:0]        interval_count;
    reg  [LW-1:0]        load_measurement_result;
    reg  [`IRQ_WIDTH-1:0] irq_status;
    reg  [`IRQ_WIDTH-1:0] irq_mask;
    reg                  ack;
    reg                  result_valid;
    reg                  stall_event;

    wire [6:0]           stall_sensitivity_offset;
    wire                 filter_en;
    wire                 diag_sel_b;
    wire                 diag_en;

    assign stall_sensitivity_offset =
        control[`CTRL_OFFSET_MSB:`CTRL_OFFSET_LSB];
    assign filter_en  = control[`CTRL_FILTER_BIT];
    assign diag_sel_b = control[`CTRL_DIAG_SEL_BIT];
    assign diag_en    = control[`CTRL_DIAG_EN_BIT];

// ----------------------------------------------------------------------
// bus handshake
// ----------------------------------------------------------------------
    wire req;
    wire wr_go;
    wire rd_go;

    assign req   = i_avs_read | i_avs_write;
    // one wait cycle, answer on the second edge
    assign o_avs_waitrequest = req & ~ack;
    assign wr_go = i_avs_write & ack;
    assign rd_go = i_avs_read & ack;

    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

// ----------------------------------------------------------------------
// step interval measurement
// ----------------------------------------------------------------------
    // saturates so the first step after a standstill reads as slowest possible velocity
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            interval_count        <= {TW{1'b0}};
            step_interval_measure <= `INTERVAL_MAX;
        end else if (i_full_step) begin
            step_interval_measure <= interval_count;
            interval_count        <= {TW{1'b0}};
        end else if (interval_count != `INTERVAL_MAX) begin
            interval_count <= interval_count + {{(TW-1){1'b0}}, 1'b1};
        end
    end

// ----------------------------------------------------------------------
// load value with sensitivity offset
// ----------------------------------------------------------------------
    wire signed [LW+1:0] offset_scaled;
    wire signed [LW+1:0] load_sum;
    reg  [LW-1:0]        load_value;

    // positive offset lifts the reading, so a stall needs more torque
    assign offset_scaled = {{(LW+2-7-`OFFSET_SHIFT){
                                stall_sensitivity_offset[6]}},
                            stall_sensitivity_offset,
                            {`OFFSET_SHIFT{1'b0}}};
    assign load_sum = $signed({2'b00, i_raw_load}) + offset_scaled;

    always @* begin
        if (load_sum[LW+1]) begin
            load_value = {LW{1'b0}};
        end else if (load_sum[LW]) begin
            load_value = `LOAD_MAX;
        end else begin
            load_value = load_sum[LW-1:0];
        end
    end

// ----------------------------------------------------------------------
// averaging filter
// ----------------------------------------------------------------------
    wire [LW-1:0] mean;
    wire          mean_valid;
    reg           filter_en_d;

    // history restarts on a mode change so no stale mix leaks out
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            filter_en_d <= 1'b0;
        end else begin
            filter_en_d <= filter_en;
        end
    end

    load_filter #(
        .W(LW)
    ) u_filter (
        .i_mclk         (i_mclk),
        .i_resetn       (i_resetn),
        .i_clear        (filter_en != filter_en_d),
        .i_sample_valid (i_full_step & filter_en),
        .i_sample       (load_value),
        .o_mean         (mean),
        .o_mean_valid   (mean_valid)
    );

// ----------------------------------------------------------------------
// result update and stall decision
// ----------------------------------------------------------------------
    wire          unfilt_upd;
    wire          new_valid;
    wire [LW-1:0] new_value;
    wire          above_lower;
    wire          below_upper;
    wire          in_band;

    assign unfilt_upd = i_full_step & ~filter_en;
    assign new_valid  = unfilt_upd | (mean_valid & filter_en);
    // unfiltered result follows each step, so the dip shows directly
    assign new_value  = unfilt_upd ? load_value : mean;

    // thresholds are step intervals: a shorter interval is faster
    assign above_lower = step_interval_measure
                         <= lower_velocity_threshold;
    assign below_upper = step_interval_measure
                         >= upper_velocity_threshold;
    assign in_band = above_lower & below_upper;

    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            load_measurement_result <= `LOAD_RESULT_RESET;
            result_valid            <= 1'b0;
        end else begin
            result_valid <= new_valid;
            if (new_valid) begin
                load_measurement_result <= new_value;
            end
        end
    end

    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            stall_event <= 1'b0;
        end else begin
            // gated outside the velocity band
            stall_event <= new_valid & (new_value == {LW{1'b0}})
                           & in_band;
        end
    end

    // one-cycle pulse on the selected diagnostic pin
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_diagnostic_output_a <= 1'b0;
            o_diagnostic_output_b <= 1'b0;
        end else begin
            o_diagnostic_output_a <= stall_event & diag_en
                                     & ~diag_sel_b;
            o_diagnostic_output_b <= stall_event & diag_en
                                     & diag_sel_b;
        end
    end

// ----------------------------------------------------------------------
// interrupt status
// ----------------------------------------------------------------------
    wire [`IRQ_WIDTH-1:0] irq_set;
    wire [`IRQ_WIDTH-1:0] irq_clr;

    assign irq_set = {result_valid, stall_event};
    // only bits already shown in the read data are cleared
    assign irq_clr = (rd_go && i_avs_address == `ADDR_IRQ_STATUS)
                     ? o_avs_readdata[`IRQ_WIDTH-1:0]
                     : {`IRQ_WIDTH{1'b0}};

    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_status & irq_mask);

// ----------------------------------------------------------------------
// register writes and reads
// ----------------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            control                  <= `CONTROL_RESET;
            lower_velocity_threshold <= `LOWER_THRESH_RESET;
            upper_velocity_threshold <= `UPPER_THRESH_RESET;
            irq_mask                 <= {`IRQ_WIDTH{1'b0}};
        end else if (wr_go) begin
            case (i_avs_address)
                `ADDR_CONTROL: begin
                    control <= i_avs_writedata[10:0];
                end
                `ADDR_LOWER_THRESH: begin
                    lower_velocity_threshold <= i_avs_writedata[TW-1:0];
                end
                `ADDR_UPPER_THRESH: begin
                    upper_velocity_threshold <= i_avs_writedata[TW-1:0];
                end
                `ADDR_IRQ_MASK: begin
                    irq_mask <= i_avs_writedata[`IRQ_WIDTH-1:0];
                end
                default: begin
                    control <= control;
                end
            endcase
        end
    end

    // read data captured on the wait edge, held through the answer edge
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read & ~ack) begin
            case (i_avs_address)
                `ADDR_CONTROL:
                    o_avs_readdata <= {21'h000000, control};
                `ADDR_LOWER_THRESH:
                    o_avs_readdata <= {{(32-TW){1'b0}},
                                       lower_velocity_threshold};
                `ADDR_UPPER_THRESH:
                    o_avs_readdata <= {{(32-TW){1'b0}},
                                       upper_velocity_threshold};
                `ADDR_STEP_INTERVAL:
                    o_avs_readdata <= {{(32-TW){1'b0}},
                                       step_interval_measure};
                `ADDR_LOAD_RESULT:
                    o_avs_readdata <= {{(32-LW){1'b0}},
                                       load_measurement_result};
                `ADDR_IRQ_STATUS:
                    o_avs_readdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_status};
                `ADDR_IRQ_MASK:
                    o_avs_readdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_mask};
                default:
                    o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ### hw/stall_detect_consts.vh
`ifndef STALL_DETECT_CONSTS_VH
`define STALL_DETECT_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADDR_CONTROL        5'h00
`define ADDR_LOWER_THRESH   5'h04
`define ADDR_UPPER_THRESH   5'h08
`define ADDR_STEP_INTERVAL  5'h0C
`define ADDR_LOAD_RESULT    5'h10
`define ADDR_IRQ_STATUS     5'h14
`define ADDR_IRQ_MASK       5'h18

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define CTRL_OFFSET_LSB     0
`define CTRL_OFFSET_MSB     6
`define CTRL_FILTER_BIT     8
`define CTRL_DIAG_SEL_BIT   9
`define CTRL_DIAG_EN_BIT    10

// ----------------------------------------------------------------------
// status / mask bits
// ----------------------------------------------------------------------
`define IRQ_STALL_BIT       0
`define IRQ_UPDATE_BIT      1
`define IRQ_WIDTH           2

// ----------------------------------------------------------------------
// widths, reset values, scaling
// ----------------------------------------------------------------------
`define LOAD_WIDTH          10
`define LOAD_MAX            10'h3FF
`define LOAD_RESULT_RESET   10'h3FF
`define OFFSET_SHIFT        4
`define INTERVAL_WIDTH      20
`define INTERVAL_MAX        20'hFFFFF
`define LOWER_THRESH_RESET  20'h00000
`define UPPER_THRESH_RESET  20'h00000
`define CONTROL_RESET       11'h000
`define FILTER_DEPTH        4

`endif

// ### tb/motion_ctrl.sv
`timescale 1ns/10ps
module motion_ctrl (
    input  wire       i_mclk,
    input  wire       i_resetn,
    input  wire       i_run,
    input  wire       i_arm,
    input  wire [7:0] i_period,
    input  wire [9:0] i_raw,
    input  wire       i_diag_a,
    input  wire       i_diag_b,
    output reg        o_full_step,
    output reg  [9:0] o_raw_load,
    output reg        o_halted
);
    reg [7:0] cnt;
    // load lines are only valid in the step cycle: show garbage otherwise
    always @(posedge i_mclk) begin
        o_full_step <= 1'b0;
        o_raw_load  <= ~i_raw;
        if (!i_resetn) begin
            cnt      <= 8'h00;
            o_halted <= 1'b0;
        end else begin
            if (i_arm && (i_diag_a || i_diag_b))
                o_halted <= 1'b1;
            else if (!i_arm)
                o_halted <= 1'b0;
            // stall tests run with the filter off, set by the bench
            if (i_run && !o_halted) begin
                cnt <= (cnt == i_period - 8'h01) ? 8'h00 : cnt + 8'h01;
                if (cnt == i_period - 8'h01) begin
                    o_full_step <= 1'b1;
                    o_raw_load  <= i_raw;
                end
            end
        end
    end
endmodule

// ### tb/stall_detect_sva.sv
`timescale 1ns/10ps
module stall_detect_sva #(
    parameter LW = 10,
    parameter TW = 20
) (
    input wire          i_mclk,
    input wire          i_resetn,
    input wire          i_full_step,
    input wire [LW-1:0] i_raw_load,
    input wire [4:0]    i_avs_address,
    input wire          i_avs_read,
    input wire          i_avs_write,
    input wire [31:0]   i_avs_writedata,
    input wire [31:0]   o_avs_readdata,
    input wire          o_avs_waitrequest,
    input wire          o_diagnostic_output_a,
    input wire          o_diagnostic_output_b,
    input wire          o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    wire any_req  = i_avs_read | i_avs_write;
    wire any_diag = o_diagnostic_output_a | o_diagnostic_output_b;
    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    sequence s_one_wait;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    a_read_wait: assert property ($rose(i_avs_read) |-> s_one_wait)
        else $error("read not answered after one wait");
    a_write_wait: assert property ($rose(i_avs_write) |-> s_one_wait)
        else $error("write not answered after one wait");
    a_idle_nowait: assert property (!any_req |-> !o_avs_waitrequest)
        else $error("waitrequest without request");
    a_rdata_hold: assert property (!(i_avs_read && o_avs_waitrequest)
        |=> $stable(o_avs_readdata))
        else $error("read data changed outside capture");
    // ------------------------------------------------------------------
    // stall pulse
    // ------------------------------------------------------------------
    a_diag_pulse: assert property (any_diag |=> !any_diag)
        else $error("stall pulse longer than one cycle");
    a_diag_single: assert property (!(o_diagnostic_output_a
        && o_diagnostic_output_b))
        else $error("both diagnostic pins pulsed");
    // off: two edges after the step, filtered: three
    a_diag_cause: assert property (any_diag |->
        $past(i_full_step, 2) || $past(i_full_step, 3))
        else $error("stall pulse without step");
    a_reset_quiet: assert property ($rose(i_resetn) |->
        !o_irq && !any_diag && o_avs_readdata == 32'h00000000)
        else $error("outputs not quiet after reset");
endmodule
bind stall_detect stall_detect_sva #(.LW(LW), .TW(TW)) u_sva (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_full_step(i_full_step),
    .i_raw_load(i_raw_load), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
    .o_diagnostic_output_a(o_diagnostic_output_a),
    .o_diagnostic_output_b(o_diagnostic_output_b));

// ### tb/tb_top.sv
`timescale 1ns/10ps
`include "stall_detect_consts.vh"
module tb_top;
    reg        i_mclk = 1'b0;
    reg        i_resetn = 1'b0;
    reg [4:0]  adr = 5'h00;
    reg        rd = 1'b0, wr = 1'b0, run = 1'b0, arm = 1'b0;
    reg [31:0] wdata = 32'h00000000, v;
    reg [9:0]  raw = 10'h100;
    wire       stp, halted, wrq, irq, da, db;
    wire [9:0] rawl;
    wire [31:0] rdata;
    integer    fails = 0, tests_run = 0, cycles = 0, na = 0, nb = 0;
    always #50 i_mclk = ~i_mclk;
    stall_detect uut (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_full_step(stp), .i_raw_load(rawl), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
        .o_diagnostic_output_a(da), .o_diagnostic_output_b(db),
        .o_irq(irq));
    motion_ctrl pc (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_run(run),
        .i_arm(arm), .i_period(8'h14), .i_raw(raw), .i_diag_a(da),
        .i_diag_b(db), .o_full_step(stp), .o_raw_load(rawl),
        .o_halted(halted));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task summarize;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (da === 1'b1) na <= na + 1;
        if (db === 1'b1) nb <= nb + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task avs(input w, input [4:0] a, input [31:0] d);
        begin
            @(posedge i_mclk);
            adr <= a;
            wdata <= d;
            wr <= w;
            rd <= !w;
            @(posedge i_mclk);
            while (wrq !== 1'b0) @(posedge i_mclk);
            v = rdata;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task rd_chk(input [4:0] a, input [31:0] e);
        begin
            avs(1'b0, a, 32'h00000000);
            check(v, e);
        end
    endtask
    // raw is set one edge ahead so the next step carries it
    task step_raw(input [9:0] r);
        begin
            @(posedge i_mclk);
            raw <= r;
            run <= 1'b1;
            @(posedge i_mclk);
            @(negedge i_mclk);
            while (stp !== 1'b1) @(negedge i_mclk);
            // four edges more so counters and halt have settled
            repeat (4) @(posedge i_mclk);
        end
    endtask
    task note(input [8*8-1:0] n);
        $display("test %0s done", n);
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd_chk(`ADDR_CONTROL, 32'h00000000);
        rd_chk(`ADDR_LOWER_THRESH, 32'h00000000);
        rd_chk(`ADDR_UPPER_THRESH, 32'h00000000);
        rd_chk(`ADDR_STEP_INTERVAL, 32'h000FFFFF);
        rd_chk(`ADDR_LOAD_RESULT, 32'h000003FF);
        rd_chk(`ADDR_IRQ_STATUS, 32'h00000000);
        rd_chk(`ADDR_IRQ_MASK, 32'h00000000);
        rd_chk(5'h1C, 32'h00000000);
        avs(1'b1, `ADDR_LOAD_RESULT, 32'h00000000);
        rd_chk(`ADDR_LOAD_RESULT, 32'h000003FF);
        note("reset");
        step_raw(10'h200);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000200);
        step_raw(10'h000);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000000);
        step_raw(10'h080);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000080);
        rd_chk(`ADDR_STEP_INTERVAL, 32'h00000013);
        avs(1'b1, `ADDR_CONTROL, 32'h00000001);
        step_raw(10'h3F8);
        rd_chk(`ADDR_LOAD_RESULT, 32'h000003FF);
        avs(1'b1, `ADDR_CONTROL, 32'h0000007F);
        step_raw(10'h155);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000145);
        avs(1'b1, `ADDR_CONTROL, 32'h00000040);
        step_raw(10'h155);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000000);
        note("load");
        // band edges are written in an order that opens the band only on the last upper write
        raw <= 10'h100;
        avs(1'b1, `ADDR_CONTROL, 32'h00000400);
        avs(1'b1, `ADDR_IRQ_MASK, 32'h00000001);
        avs(1'b1, `ADDR_LOWER_THRESH, 32'h00000012);
        step_raw(10'h000);
        step_raw(10'h000);
        rd_chk(`ADDR_IRQ_STATUS, 32'h00000002);
        check(na, 0);
        check(irq, 1'b0);
        raw <= 10'h100;
        avs(1'b1, `ADDR_UPPER_THRESH, 32'h00000014);
        avs(1'b1, `ADDR_LOWER_THRESH, 32'h000FFFFF);
        step_raw(10'h000);
        step_raw(10'h000);
        rd_chk(`ADDR_IRQ_STATUS, 32'h00000002);
        check(na, 0);
        raw <= 10'h100;
        avs(1'b1, `ADDR_LOWER_THRESH, 32'h00000013);
        avs(1'b1, `ADDR_UPPER_THRESH, 32'h00000013);
        avs(1'b0, `ADDR_IRQ_STATUS, 32'h00000000);
        arm <= 1'b1;
        step_raw(10'h000);
        check(na, 1);
        check(halted, 1'b1);
        check(irq, 1'b1);
        rd_chk(`ADDR_IRQ_STATUS, 32'h00000003);
        @(negedge i_mclk);
        check(irq, 1'b0);
        rd_chk(`ADDR_IRQ_STATUS, 32'h00000000);
        avs(1'b1, `ADDR_CONTROL, 32'h00000600);
        avs(1'b1, `ADDR_IRQ_MASK, 32'h00000000);
        raw <= 10'h100;
        arm <= 1'b0;
        @(posedge i_mclk);
        arm <= 1'b1;
        step_raw(10'h000);
        check(nb, 1);
        check(na, 1);
        check(irq, 1'b0);
        note("band");
        arm <= 1'b0;
        avs(1'b1, `ADDR_CONTROL, 32'h00000000);
        avs(1'b1, `ADDR_LOWER_THRESH, 32'h00000000);
        step_raw(10'h155);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000155);
        run <= 1'b0;
        avs(1'b1, `ADDR_CONTROL, 32'h00000100);
        step_raw(10'h064);
        step_raw(10'h0C8);
        step_raw(10'h12C);
        rd_chk(`ADDR_LOAD_RESULT, 32'h00000155);
        step_raw(10'h190);
        rd_chk(`ADDR_LOAD_RESULT, 32'h000000FA);
        note("filter");
        summarize;
    end
endmodule
